/* hw/pfpp_regs.svh */
// register offsets, pin encodings and timing counts of the flash programming port
`ifndef PFPP_REGS_SVH
`define PFPP_REGS_SVH

`define PFPP_CLK_MHZ 25
`define PFPP_CYC(ns) ((((ns) * `PFPP_CLK_MHZ) + 999) / 1000)

`define PFPP_T_SETUP_NS 1000
`define PFPP_T_VPP_NS 10000
`define PFPP_T_PULSE_NS 2000
`define PFPP_T_STEP_NS 200
`define PFPP_T_WRITE_NS 1200000
`define PFPP_T_ERASE_NS 10000000

`define PFPP_ARRAY_BYTES 2048
`define PFPP_BLANK 8'hFF
`define PFPP_ADDR_ZERO 11'h000
`define PFPP_SIG_ADDR1 11'h001
`define PFPP_SIG_ADDR2 11'h002

// select patterns, bit order {a,b,c,d}
`define PFPP_SEL_WRITE_CODE 4'h7
`define PFPP_SEL_READ_CODE 4'h3
`define PFPP_SEL_LOCK_ONE 4'hF
`define PFPP_SEL_LOCK_TWO 4'hC
`define PFPP_SEL_ERASE 4'h8
`define PFPP_SEL_READ_SIG 4'h0

`define PFPP_OFF_CMD 12'h000
`define PFPP_OFF_STATUS 12'h004
`define PFPP_OFF_DATA 12'h008
`define PFPP_OFF_ADDR 12'h00C

`define PFPP_CMD_POWER_UP 4'h1
`define PFPP_CMD_WRITE_CODE 4'h2
`define PFPP_CMD_READ_CODE 4'h3
`define PFPP_CMD_STEP 4'h4
`define PFPP_CMD_LOCK_ONE 4'h5
`define PFPP_CMD_LOCK_TWO 4'h6
`define PFPP_CMD_ERASE 4'h7
`define PFPP_CMD_READ_SIG 4'h8
`define PFPP_CMD_POWER_OFF 4'h9

`endif

/* hw/pfpp_pkg.sv */
// types shared by both ends of the flash programming port
package pfpp_pkg;
  typedef enum logic [2:0] {
    MODE_NONE, MODE_WRITE_CODE, MODE_READ_CODE, MODE_LOCK_ONE, MODE_LOCK_TWO, MODE_ERASE, MODE_READ_SIG
  } pfpp_mode_t;
  typedef enum logic [1:0] {D_IDLE, D_WRITE, D_ERASE} pfpp_dev_state_t;
  typedef enum logic [3:0] {
    P_IDLE, P_RST_LO, P_RST_HI, P_SETUP, P_VPP, P_STROBE, P_HOLD, P_BUSY, P_READ, P_PUSH, P_STEP_HI, P_STEP_LO, P_OFF
  } pfpp_program_pulse_state_t;
endpackage

/* hw/pfpp_if.sv */
// pin bundle between the flash device and its external programmer
`timescale 1ns/10ps
interface pfpp_if;
  logic rst_level_high;
  logic vpp_on;
  logic program_pulse_pin;
  logic select_line_a;
  logic select_line_b;
  logic select_line_c;
  logic select_line_d;
  logic address_step_clock;
  logic [7:0] program_pulse_data_out;
  logic program_pulse_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic busy_indicator_pin;
  logic [7:0] code_data_port;

  // pull-ups hold an undriven port high
  assign code_data_port = dev_data_oe ? dev_data_out : (program_pulse_data_oe ? program_pulse_data_out : 8'hFF);

  modport device (
    input rst_level_high, vpp_on, program_pulse_pin, select_line_a, select_line_b, select_line_c,
    input select_line_d, address_step_clock, code_data_port,
    output dev_data_out, dev_data_oe, busy_indicator_pin
  );
  modport programmer (
    output rst_level_high, vpp_on, program_pulse_pin, select_line_a, select_line_b, select_line_c,
    output select_line_d, address_step_clock, program_pulse_data_out, program_pulse_data_oe,
    input busy_indicator_pin, code_data_port
  );
endinterface // pfpp_if

/* hw/pfpp_device.sv */
// device end: code array, lock bits, address counter and pin protocol
// Functional notes
// - two lock bits gate programming and verify
// - only chip erase or reset clears the lock bits
// - array starts erased, every byte FFH
// - one byte per write, non-blank bytes kept
// - reset rise clears address, step increments it
// - programmer powers up low, then reset high
// - programmer applies data, then raises 12V
// - select lines decode the six operations
// - strobe pulse starts self-timed 1.2 ms write
// - read mode at logic high returns addressed byte
// - programmer steps address and repeats per byte
// - polling bit inverted while write runs
// - busy pin low during write, high when done
// - lock bits have no readback path
// - 10 ms erase strobe clears array and locks
// - signature bytes at 000H to 002H
// - power-off: step clock low, then reset low
`timescale 1ns/10ps
`include "pfpp_regs.svh"
module pfpp_device #(
  parameter int WRITE_CYCLES = `PFPP_CYC(`PFPP_T_WRITE_NS),
  parameter int ERASE_CYCLES = `PFPP_CYC(`PFPP_T_ERASE_NS),
  parameter logic [7:0] SIG_MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] SIG_PART = 8'h3C, // arbitrary value
  parameter logic [7:0] SIG_THIRD = 8'hC3 // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  pfpp_if.device link,
  output logic flash_busy,
  output logic [10:0] code_address
);
  localparam logic [15:0] SYNC_RESET = 16'h20FF;
  localparam logic [23:0] WRITE_LAST = 24'(WRITE_CYCLES - 1);
  localparam logic [23:0] ERASE_MIN = 24'(ERASE_CYCLES);
  localparam logic [10:0] LAST_ADDR = 11'(`PFPP_ARRAY_BYTES - 1);

  logic [15:0] pins_meta;
  logic [15:0] pins;
  logic rst_q;
  logic step_q;
  logic strobe_q;
  logic pin_rst;
  logic pin_vpp;
  logic pin_strobe;
  logic pin_step;
  logic [3:0] pin_sel;
  logic [7:0] pin_data;
  logic rst_rise;
  logic step_rise;
  logic strobe_rise;
  pfpp_pkg::pfpp_mode_t mode;
  pfpp_pkg::pfpp_mode_t wr_kind;
  pfpp_pkg::pfpp_dev_state_t state;
  logic [10:0] addr;
  logic [10:0] sweep;
  logic [10:0] last_addr;
  logic [7:0] last_data;
  logic [23:0] timer;
  logic [23:0] low_cnt;
  logic write_ok;
  logic commit;
  logic lock_bit_one;
  logic lock_bit_two;
  logic program_off;
  logic verify_off;
  logic read_en;
  logic [7:0] read_byte;
  logic [7:0] mem_q;
  logic [7:0] flash_code_array [`PFPP_ARRAY_BYTES];

  // every pin comes from the programmer's side, so two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta <= SYNC_RESET;
      pins <= SYNC_RESET;
    end else begin
      pins_meta <= {link.rst_level_high, link.vpp_on, link.program_pulse_pin, link.select_line_a,
                    link.select_line_b, link.select_line_c, link.select_line_d, link.address_step_clock,
                    link.code_data_port};
      pins <= pins_meta;
    end
  end

  assign pin_rst = pins[15];
  assign pin_vpp = pins[14];
  assign pin_strobe = pins[13];
  assign pin_sel = pins[12:9];
  assign pin_step = pins[8];
  assign pin_data = pins[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= 1'b0;
      step_q <= 1'b0;
      strobe_q <= 1'b1;
    end else begin
      rst_q <= pin_rst;
      step_q <= pin_step;
      strobe_q <= pin_strobe;
    end
  end

  assign rst_rise = pin_rst & ~rst_q;
  assign step_rise = pin_step & ~step_q;
  assign strobe_rise = pin_strobe & ~strobe_q;

  always_comb begin
    mode = pfpp_pkg::MODE_NONE;
    case (pin_sel)
      `PFPP_SEL_WRITE_CODE: mode = pfpp_pkg::MODE_WRITE_CODE;
      `PFPP_SEL_READ_CODE: mode = pfpp_pkg::MODE_READ_CODE;
      `PFPP_SEL_LOCK_ONE: mode = pfpp_pkg::MODE_LOCK_ONE;
      `PFPP_SEL_LOCK_TWO: mode = pfpp_pkg::MODE_LOCK_TWO;
      `PFPP_SEL_ERASE: mode = pfpp_pkg::MODE_ERASE;
      `PFPP_SEL_READ_SIG: mode = pfpp_pkg::MODE_READ_SIG;
      default: mode = pfpp_pkg::MODE_NONE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr <= `PFPP_ADDR_ZERO;
    end else if (rst_rise) begin
      addr <= `PFPP_ADDR_ZERO;
    end else if (step_rise) begin
      addr <= addr + 11'h001;
    end
  end

  // measures how long the strobe has been held low, for erase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 24'h00_0000;
    end else if (pin_strobe) begin
      low_cnt <= 24'h00_0000;
    end else if (low_cnt != ERASE_MIN) begin
      low_cnt <= low_cnt + 24'h00_0001;
    end
  end

  assign program_off = lock_bit_one;
  assign verify_off = lock_bit_one & lock_bit_two;
  assign commit = (state == pfpp_pkg::D_WRITE) && (timer == WRITE_LAST);

  // reset enters the erase sweep so the array starts blank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pfpp_pkg::D_ERASE;
      timer <= 24'h00_0000;
      sweep <= `PFPP_ADDR_ZERO;
      wr_kind <= pfpp_pkg::MODE_NONE;
      last_addr <= `PFPP_ADDR_ZERO;
      last_data <= `PFPP_BLANK;
      write_ok <= 1'b0;
    end else begin
      case (state)
        pfpp_pkg::D_IDLE: begin
          if (strobe_rise && pin_vpp) begin
            wr_kind <= mode;
            timer <= 24'h00_0000;
            case (mode)
              pfpp_pkg::MODE_WRITE_CODE: begin
                last_addr <= addr;
                last_data <= pin_data;
                write_ok <= !program_off && (mem_q == `PFPP_BLANK);
                state <= pfpp_pkg::D_WRITE;
              end
              pfpp_pkg::MODE_LOCK_ONE, pfpp_pkg::MODE_LOCK_TWO: begin
                write_ok <= 1'b0;
                state <= pfpp_pkg::D_WRITE;
              end
              pfpp_pkg::MODE_ERASE: begin
                if (low_cnt == ERASE_MIN) begin
                  sweep <= `PFPP_ADDR_ZERO;
                  state <= pfpp_pkg::D_ERASE;
                end
              end
              default: begin
              end
            endcase
          end
        end
        pfpp_pkg::D_WRITE: begin
          if (timer == WRITE_LAST) begin
            state <= pfpp_pkg::D_IDLE;
          end else begin
            timer <= timer + 24'h00_0001;
          end
        end
        pfpp_pkg::D_ERASE: begin
          if (sweep == LAST_ADDR) begin
            state <= pfpp_pkg::D_IDLE;
          end else begin
            sweep <= sweep + 11'h001;
          end
        end
        default: state <= pfpp_pkg::D_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk) begin
    if (state == pfpp_pkg::D_ERASE) begin
      flash_code_array[sweep] <= `PFPP_BLANK;
    end else if (commit && write_ok) begin
      flash_code_array[last_addr] <= last_data;
    end
    mem_q <= flash_code_array[addr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_bit_one <= 1'b0;
      lock_bit_two <= 1'b0;
    end else if (state == pfpp_pkg::D_ERASE) begin
      lock_bit_one <= 1'b0;
      lock_bit_two <= 1'b0;
    end else if (commit) begin
      if (wr_kind == pfpp_pkg::MODE_LOCK_ONE) begin
        lock_bit_one <= 1'b1;
      end
      if (wr_kind == pfpp_pkg::MODE_LOCK_TWO) begin
        lock_bit_two <= 1'b1;
      end
    end
  end

  assign read_en = pin_rst && !pin_vpp && pin_strobe &&
                   (mode == pfpp_pkg::MODE_READ_CODE || mode == pfpp_pkg::MODE_READ_SIG);

  // the lock bits enter this mux only through verify_off, which forces FFH
  always_comb begin
    read_byte = `PFPP_BLANK;
    if (mode == pfpp_pkg::MODE_READ_SIG) begin
      case (addr)
        `PFPP_ADDR_ZERO: read_byte = SIG_MAKER;
        `PFPP_SIG_ADDR1: read_byte = SIG_PART;
        `PFPP_SIG_ADDR2: read_byte = SIG_THIRD;
        default: read_byte = `PFPP_BLANK;
      endcase
    end else if (verify_off) begin
      read_byte = `PFPP_BLANK;
    end else if (state == pfpp_pkg::D_WRITE && addr == last_addr) begin
      read_byte = {~last_data[7], last_data[6:0]};
    end else begin
      read_byte = mem_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.dev_data_out <= `PFPP_BLANK;
      link.dev_data_oe <= 1'b0;
      link.busy_indicator_pin <= 1'b0;
      flash_busy <= 1'b1;
      code_address <= `PFPP_ADDR_ZERO;
    end else begin
      link.dev_data_out <= read_byte;
      link.dev_data_oe <= read_en;
      link.busy_indicator_pin <= (state == pfpp_pkg::D_IDLE);
      flash_busy <= (state != pfpp_pkg::D_IDLE);
      code_address <= addr;
    end
  end
endmodule // pfpp_device

/* hw/pfpp_programmer.sv */
// programmer end: apb command registers, pin sequencer and two-entry read buffer
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps
`include "pfpp_regs.svh"
module pfpp_programmer #(
  parameter int ERASE_CYCLES = `PFPP_CYC(`PFPP_T_ERASE_NS)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pfpp_if.programmer link
);
  localparam logic [23:0] GAP = 24'(`PFPP_CYC(`PFPP_T_SETUP_NS));
  localparam logic [23:0] VPP_WAIT = 24'(`PFPP_CYC(`PFPP_T_VPP_NS));
  localparam logic [23:0] PULSE = 24'(`PFPP_CYC(`PFPP_T_PULSE_NS));
  localparam logic [23:0] STEP_HIGH = 24'(`PFPP_CYC(`PFPP_T_STEP_NS));
  localparam logic [23:0] ERASE_HOLD = 24'(ERASE_CYCLES + `PFPP_CYC(`PFPP_T_SETUP_NS));

  pfpp_pkg::pfpp_program_pulse_state_t state;
  logic [8:0] in_meta;
  logic [8:0] in_sync;
  logic [23:0] cnt;
  logic cmd_go;
  logic [3:0] cmd_code;
  logic [3:0] cmd_sel;
  logic [7:0] wdata;
  logic [7:0] sample;
  logic is_erase;
  logic [10:0] addr_mirror;
  logic [7:0] fifo_mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] fifo_cnt;
  logic push;
  logic pop;
  logic pop_armed;
  logic setup;
  logic done;
  logic mapped;
  logic [31:0] read_mux;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta <= 9'h0FF;
      in_sync <= 9'h0FF;
    end else begin
      in_meta <= {link.busy_indicator_pin, link.code_data_port};
      in_sync <= in_meta;
    end
  end

  always_comb begin
    cmd_sel = `PFPP_SEL_READ_SIG;
    case (cmd_code)
      `PFPP_CMD_WRITE_CODE: cmd_sel = `PFPP_SEL_WRITE_CODE;
      `PFPP_CMD_READ_CODE: cmd_sel = `PFPP_SEL_READ_CODE;
      `PFPP_CMD_LOCK_ONE: cmd_sel = `PFPP_SEL_LOCK_ONE;
      `PFPP_CMD_LOCK_TWO: cmd_sel = `PFPP_SEL_LOCK_TWO;
      `PFPP_CMD_ERASE: cmd_sel = `PFPP_SEL_ERASE;
      default: cmd_sel = `PFPP_SEL_READ_SIG;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pfpp_pkg::P_IDLE;
      cnt <= 24'h00_0000;
      is_erase <= 1'b0;
      sample <= 8'h00;
      addr_mirror <= 11'h000;
      link.rst_level_high <= 1'b0;
      link.vpp_on <= 1'b0;
      link.program_pulse_pin <= 1'b1;
      {link.select_line_a, link.select_line_b, link.select_line_c, link.select_line_d} <= 4'h0;
      link.address_step_clock <= 1'b0;
      link.program_pulse_data_out <= 8'h00;
      link.program_pulse_data_oe <= 1'b0;
    end else begin
      if (cnt != 24'h00_0000) begin
        cnt <= cnt - 24'h00_0001;
      end
      case (state)
        pfpp_pkg::P_IDLE: begin
          if (cmd_go) begin
            case (cmd_code)
              `PFPP_CMD_POWER_UP: begin
                link.rst_level_high <= 1'b0;
                link.address_step_clock <= 1'b0;
                link.program_pulse_pin <= 1'b1;
                cnt <= GAP;
                state <= pfpp_pkg::P_RST_LO;
              end
              `PFPP_CMD_WRITE_CODE, `PFPP_CMD_LOCK_ONE, `PFPP_CMD_LOCK_TWO, `PFPP_CMD_ERASE: begin
                {link.select_line_a, link.select_line_b, link.select_line_c, link.select_line_d} <= cmd_sel;
                link.program_pulse_data_out <= wdata;
                link.program_pulse_data_oe <= (cmd_code == `PFPP_CMD_WRITE_CODE);
                is_erase <= (cmd_code == `PFPP_CMD_ERASE);
                cnt <= GAP;
                state <= pfpp_pkg::P_SETUP;
              end
              `PFPP_CMD_READ_CODE, `PFPP_CMD_READ_SIG: begin
                {link.select_line_a, link.select_line_b, link.select_line_c, link.select_line_d} <= cmd_sel;
                link.program_pulse_data_oe <= 1'b0;
                cnt <= GAP;
                state <= pfpp_pkg::P_READ;
              end
              `PFPP_CMD_STEP: begin
                link.address_step_clock <= 1'b1;
                cnt <= STEP_HIGH;
                state <= pfpp_pkg::P_STEP_HI;
              end
              `PFPP_CMD_POWER_OFF: begin
                link.address_step_clock <= 1'b0;
                cnt <= GAP;
                state <= pfpp_pkg::P_OFF;
              end
              default: begin
              end
            endcase
          end
        end
        pfpp_pkg::P_RST_LO: begin
          if (cnt == 24'h00_0000) begin
            link.rst_level_high <= 1'b1;
            cnt <= GAP;
            state <= pfpp_pkg::P_RST_HI;
          end
        end
        pfpp_pkg::P_RST_HI: begin
          if (cnt == 24'h00_0000) begin
            addr_mirror <= 11'h000;
            state <= pfpp_pkg::P_IDLE;
          end
        end
        pfpp_pkg::P_SETUP: begin
          if (cnt == 24'h00_0000) begin
            link.vpp_on <= 1'b1;
            cnt <= VPP_WAIT;
            state <= pfpp_pkg::P_VPP;
          end
        end
        pfpp_pkg::P_VPP: begin
          if (cnt == 24'h00_0000) begin
            link.program_pulse_pin <= 1'b0;
            cnt <= is_erase ? ERASE_HOLD : PULSE;
            state <= pfpp_pkg::P_STROBE;
          end
        end
        pfpp_pkg::P_STROBE: begin
          if (cnt == 24'h00_0000) begin
            link.program_pulse_pin <= 1'b1;
            cnt <= VPP_WAIT;
            state <= pfpp_pkg::P_HOLD;
          end
        end
        pfpp_pkg::P_HOLD: begin
          if (cnt == 24'h00_0000) begin
            state <= pfpp_pkg::P_BUSY;
          end
        end
        pfpp_pkg::P_BUSY: begin
          if (in_sync[8]) begin
            link.vpp_on <= 1'b0;
            link.program_pulse_data_oe <= 1'b0;
            state <= pfpp_pkg::P_IDLE;
          end
        end
        pfpp_pkg::P_READ: begin
          if (cnt == 24'h00_0000) begin
            sample <= in_sync[7:0];
            state <= pfpp_pkg::P_PUSH;
          end
        end
        pfpp_pkg::P_PUSH: begin
          if (push) begin
            state <= pfpp_pkg::P_IDLE;
          end
        end
        pfpp_pkg::P_STEP_HI: begin
          if (cnt == 24'h00_0000) begin
            link.address_step_clock <= 1'b0;
            cnt <= STEP_HIGH;
            state <= pfpp_pkg::P_STEP_LO;
          end
        end
        pfpp_pkg::P_STEP_LO: begin
          if (cnt == 24'h00_0000) begin
            addr_mirror <= addr_mirror + 11'h001;
            state <= pfpp_pkg::P_IDLE;
          end
        end
        pfpp_pkg::P_OFF: begin
          if (cnt == 24'h00_0000) begin
            link.rst_level_high <= 1'b0;
            link.vpp_on <= 1'b0;
            state <= pfpp_pkg::P_IDLE;
          end
        end
        default: state <= pfpp_pkg::P_IDLE;
      endcase
    end
  end

  // sequencer stalls in P_PUSH while both entries are full
  assign push = (state == pfpp_pkg::P_PUSH) && (fifo_cnt != 2'd2);
  assign pop = done && pop_armed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_mem[0] <= 8'h00;
      fifo_mem[1] <= 8'h00;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fifo_cnt <= 2'd0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr] <= sample;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  assign setup = psel && !penable && !pready;
  assign done = psel && penable && pready;
  assign mapped = (paddr == `PFPP_OFF_CMD) || (paddr == `PFPP_OFF_STATUS) ||
                  (paddr == `PFPP_OFF_DATA) || (paddr == `PFPP_OFF_ADDR);

  always_comb begin
    read_mux = 32'h0000_0000;
    case (paddr)
      `PFPP_OFF_CMD: read_mux = {28'h000_0000, cmd_code};
      `PFPP_OFF_STATUS: read_mux = {28'h000_0000, in_sync[8], fifo_cnt == 2'd2, fifo_cnt != 2'd0,
                                    cmd_go || (state != pfpp_pkg::P_IDLE)};
      `PFPP_OFF_DATA: read_mux = {24'h00_0000, (fifo_cnt != 2'd0) ? fifo_mem[rd_ptr] : 8'h00};
      `PFPP_OFF_ADDR: read_mux = {21'h00_0000, addr_mirror};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      pop_armed <= 1'b0;
      cmd_go <= 1'b0;
      cmd_code <= 4'h0;
      wdata <= 8'h00;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      cmd_go <= 1'b0;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : read_mux;
        pop_armed <= !pwrite && (paddr == `PFPP_OFF_DATA) && (fifo_cnt != 2'd0);
      end
      if (done && pwrite && paddr == `PFPP_OFF_DATA) begin
        wdata <= pwdata[7:0];
      end
      if (done && pwrite && paddr == `PFPP_OFF_CMD && state == pfpp_pkg::P_IDLE && !cmd_go) begin
        cmd_code <= pwdata[3:0];
        cmd_go <= 1'b1;
      end
    end
  end
endmodule // pfpp_programmer

/* sim/pfpp_monitor.sv */
// assertions on the pins between programmer and device
`timescale 1ns/10ps
module pfpp_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rst_level_high,
  input wire logic vpp_on,
  input wire logic program_pulse_pin,
  input wire logic select_line_a,
  input wire logic select_line_b,
  input wire logic select_line_c,
  input wire logic select_line_d,
  input wire logic address_step_clock,
  input wire logic dev_data_oe,
  input wire logic busy_indicator_pin
);
  // longest busy stretch is the erase sweep that follows reset
  localparam logic [11:0] BUSY_LIMIT = 12'h834;
  logic [11:0] busy_len;
  // cycles the ready/busy pin has been low, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_len <= 12'h000;
    end else if (busy_indicator_pin) begin
      busy_len <= 12'h000;
    end else if (busy_len != 12'hFFF) begin
      busy_len <= busy_len + 12'h001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence busy_run;
    !busy_indicator_pin [*8];
  endsequence
  sequence busy_start;
    $fell(busy_indicator_pin);
  endsequence
  busy_min_a: assert property (busy_start |-> busy_run) else $error("busy pulse too short");
  busy_end_a: assert property (busy_len <= BUSY_LIMIT) else $error("busy never ends");
  busy_cause_a: assert property (busy_start |-> $past(program_pulse_pin) && !$past(program_pulse_pin, 12))
    else $error("busy without strobe");
  port_off_a: assert property (vpp_on && $past(vpp_on, 6) |-> !dev_data_oe) else $error("port driven at 12V");
  vpp_rst_a: assert property (vpp_on |-> rst_level_high) else $error("12V without reset high");
  strobe_vpp_a: assert property ($fell(program_pulse_pin) |-> vpp_on && $past(vpp_on, 8))
    else $error("strobe without 12V");
  sel_hold_a: assert property (!program_pulse_pin |-> $stable({select_line_a, select_line_b, select_line_c,
    select_line_d})) else $error("selects move in strobe");
  step_off_a: assert property ($fell(rst_level_high) |-> !address_step_clock && !$past(address_step_clock, 2))
    else $error("step high at reset fall");
endmodule // pfpp_monitor

/* sim/tb.sv */
// self-checking bench joining programmer and device ends over apb
`timescale 1ns/10ps
`include "pfpp_regs.svh"
`define CHK(gv, ev) begin total_checks++; if ((gv) !== (ev)) begin errors++; $display("Error %0t: got %h exp %h", $time, gv, ev); end end
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic dev_busy;
  logic [10:0] dev_addr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = '0, prdata, q;
  logic [7:0] sig [3] = '{8'h5A, 8'h3C, 8'hC3};
  int errors = 0, total_checks = 0, cyc = 0;
  pfpp_if pfpp_if_i ();
  pfpp_device #(.WRITE_CYCLES(40), .ERASE_CYCLES(60)) pfpp_device_i (.pclk(pclk), .presetn(presetn),
    .link(pfpp_if_i), .flash_busy(dev_busy), .code_address(dev_addr));
  pfpp_programmer #(.ERASE_CYCLES(60)) pfpp_programmer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(pfpp_if_i));
  pfpp_monitor pfpp_monitor_i (.pclk(pclk), .presetn(presetn), .rst_level_high(pfpp_if_i.rst_level_high),
    .vpp_on(pfpp_if_i.vpp_on), .program_pulse_pin(pfpp_if_i.program_pulse_pin),
    .select_line_a(pfpp_if_i.select_line_a), .select_line_b(pfpp_if_i.select_line_b),
    .select_line_c(pfpp_if_i.select_line_c), .select_line_d(pfpp_if_i.select_line_d),
    .address_step_clock(pfpp_if_i.address_step_clock), .dev_data_oe(pfpp_if_i.dev_data_oe),
    .busy_indicator_pin(pfpp_if_i.busy_indicator_pin));
  always #20 pclk = ~pclk;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // wait for the sequencer to go idle again
  task automatic cmd(input logic [3:0] c);
    apb(1'b1, `PFPP_OFF_CMD, {28'h000_0000, c});
    do apb(1'b0, `PFPP_OFF_STATUS, '0); while (q[0] !== 1'b0);
  endtask
  task automatic pop(input logic [31:0] x);
    apb(1'b0, `PFPP_OFF_DATA, '0);
    `CHK(q, x)
  endtask
  task automatic rdb(input logic [7:0] x);
    cmd(`PFPP_CMD_READ_CODE);
    pop({24'h00_0000, x});
  endtask
  task automatic wr(input logic [7:0] x);
    apb(1'b1, `PFPP_OFF_DATA, {24'h00_0000, x});
    cmd(`PFPP_CMD_WRITE_CODE);
  endtask
  task final_report;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    do apb(1'b0, `PFPP_OFF_STATUS, '0); while (q[3] !== 1'b1);
    `CHK(dev_busy, 1'b0)
    cmd(`PFPP_CMD_POWER_UP);
    apb(1'b0, `PFPP_OFF_ADDR, '0);
    `CHK(q, 32'h0000_0000)
    `CHK(dev_addr, 11'h000)
    rdb(8'hFF);
    cmd(`PFPP_CMD_STEP);
    apb(1'b0, `PFPP_OFF_ADDR, '0);
    `CHK(q, 32'h0000_0001)
    `CHK(dev_addr, 11'h001)
    wr(8'hA5);
    cmd(`PFPP_CMD_READ_CODE);
    cmd(`PFPP_CMD_READ_CODE);
    apb(1'b0, `PFPP_OFF_STATUS, '0);
    `CHK(q[2:1], 2'b11)
    pop(32'h0000_00A5);
    pop(32'h0000_00A5);
    pop(32'h0000_0000);
    wr(8'h0F);
    rdb(8'hA5);
    cmd(`PFPP_CMD_STEP);
    wr(8'h3C);
    cmd(`PFPP_CMD_LOCK_ONE);
    rdb(8'h3C);
    cmd(`PFPP_CMD_STEP);
    wr(8'h11);
    rdb(8'hFF);
    cmd(`PFPP_CMD_POWER_UP);
    cmd(`PFPP_CMD_STEP);
    cmd(`PFPP_CMD_LOCK_TWO);
    rdb(8'hFF);
    cmd(`PFPP_CMD_POWER_UP);
    foreach (sig[i]) begin
      cmd(`PFPP_CMD_READ_SIG);
      pop({24'h00_0000, sig[i]});
      cmd(`PFPP_CMD_STEP);
    end
    cmd(`PFPP_CMD_POWER_UP);
    cmd(`PFPP_CMD_ERASE);
    cmd(`PFPP_CMD_STEP);
    rdb(8'hFF);
    wr(8'h77);
    rdb(8'h77);
    apb(1'b0, 12'h010, '0);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
    cmd(`PFPP_CMD_POWER_OFF);
    final_report;
  end
endmodule // tb
